/* File: core/pack_protection_control.sv */
/*
 * Pack protection control: FET enables, fault status with interrupt,
 * external trip detection, load sensing and cell balancing gating.
 * Assumes a host on classic Wishbone, one 200 MHz clock, pins that are
 * asynchronous and analog decisions (cell limits) arriving on the clock.
 */
// Our own choices: the Wishbone register port and the placing of the registers.
// Function
// - FET drivers follow their enable bits
// - faults and sleep entry clear FET enables
// - device never raises FET enables itself
// - persisting cell limit faults set again
// - load sensing only while charge disabled
// - one balance bit per cell
// - balancing limited to seventy percent per period
// - balancing paused during measurement slice
// - chip fault or wake clears balance bits
// - interrupt is OR of status bits
// - write one clears status, interrupt auto-releases
// - external high on pin trips both FETs
// - no external detection while driving high
// - pin level used without debounce
// - comparators sampled, delay-qualified, then trip
`timescale 1ns/1ps
module pack_protection_control #(
    parameter int unsigned SAMPLE_DIV   = pack_protection_pkg::SAMPLE_DIV_CYC,
    parameter int unsigned PERIOD_TICKS = pack_protection_pkg::BAL_PERIOD_TICKS
) (
    input  wire logic                         i_sys_clk,
    input  wire logic                         i_rst_n,
    input  wire pack_protection_pkg::wb_req_t i_wb_req,
    output pack_protection_pkg::wb_rsp_t      o_wb_rsp,
    input  wire logic                         i_ov_cond,
    input  wire logic                         i_uv_cond,
    input  wire logic                         i_ocd_cmp,
    input  wire logic                         i_scd_cmp,
    input  wire logic                         i_chip_fault,
    input  wire logic                         i_load_pin,
    input  wire logic                         i_wake_pin,
    input  wire logic                         i_alert_pin,
    output logic                              o_alert_out,
    output logic                              o_alert_oe,
    output logic                              o_chg_drv,
    output logic                              o_dsg_drv,
    output logic [14:0]                       o_balance,
    output logic                              o_meas_slice
);
    localparam int unsigned BAL_ON_TICKS = PERIOD_TICKS * pack_protection_pkg::BAL_DUTY_PCT / 100;

    pack_protection_pkg::ctrl_state_t r_q;
    pack_protection_pkg::ctrl_state_t r_d;

    logic                               sample_tick;
    logic [15:0]                        phase_cnt;
    logic                               ocd_fire;
    logic                               scd_fire;
    logic                               normal;
    logic                               hit;
    logic                               wr;
    logic [pack_protection_pkg::ST_W-1:0] set_vec;
    logic                               ext_det;
    logic                               enter_sleep;
    logic                               wake;
    logic                               clr_chg;
    logic                               clr_dsg;
    logic                               wr_stat;
    logic                               wr_ctrl2;
    logic                               phase_on;
    logic [31:0]                        rdata;

    // ************************************************************
    // sample rate and balancing period
    // ************************************************************
    // 32 kHz sample enable
    tick_divider #(.DIV(SAMPLE_DIV)) u_sample_div (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_en      (1'b1),
        .o_tick    (sample_tick),
        .o_count   ()
    );

    tick_divider #(.DIV(PERIOD_TICKS)) u_period_div (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_en      (sample_tick),
        .o_tick    (),
        .o_count   (phase_cnt)
    );

    trip_qualifier u_ocd_qual (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_tick    (sample_tick),
        .i_arm     (normal),
        .i_cmp     (r_q.sync2[pack_protection_pkg::SY_OCD]),
        .i_delay   (r_q.ocd_dly),
        .o_fire    (ocd_fire)
    );

    trip_qualifier u_scd_qual (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_tick    (sample_tick),
        .i_arm     (normal),
        .i_cmp     (r_q.sync2[pack_protection_pkg::SY_SCD]),
        .i_delay   (r_q.scd_dly),
        .o_fire    (scd_fire)
    );

    // ************************************************************
    // bus decode and read mux
    // ************************************************************
    // write lands on the edge where ack is seen high
    always_comb begin
        hit      = i_wb_req.cyc & i_wb_req.stb;
        wr       = hit & i_wb_req.we & r_q.rsp.ack & i_wb_req.sel[0];
        wr_stat  = wr & (i_wb_req.adr == pack_protection_pkg::OFS_STATUS);
        wr_ctrl2 = wr & (i_wb_req.adr == pack_protection_pkg::OFS_CTRL2);
        rdata    = 32'h0000_0000;
        if (i_wb_req.adr == pack_protection_pkg::OFS_STATUS) begin
            rdata[5:0] = r_q.status;
        end else if (i_wb_req.adr == pack_protection_pkg::OFS_EQ0) begin
            rdata[4:0] = r_q.eq[4:0];
        end else if (i_wb_req.adr == pack_protection_pkg::OFS_EQ1) begin
            rdata[4:0] = r_q.eq[9:5];
        end else if (i_wb_req.adr == pack_protection_pkg::OFS_EQ2) begin
            rdata[4:0] = r_q.eq[14:10];
        end else if (i_wb_req.adr == pack_protection_pkg::OFS_CTRL1) begin
            rdata[pack_protection_pkg::C1_LOAD]  = r_q.load;
            rdata[pack_protection_pkg::C1_SLEEP] = (r_q.pwr == pack_protection_pkg::ST_SLEEP);
            rdata[pack_protection_pkg::C1_CONV]  = r_q.conv;
        end else if (i_wb_req.adr == pack_protection_pkg::OFS_CTRL2) begin
            rdata[pack_protection_pkg::C2_CHG] = r_q.charge_driver_pin;
            rdata[pack_protection_pkg::C2_DSG] = r_q.discharge_driver_pin;
        end else if (i_wb_req.adr == pack_protection_pkg::OFS_DELAY) begin
            rdata[15:0] = {r_q.scd_dly, r_q.ocd_dly};
        end
    end

    // ************************************************************
    // events
    // ************************************************************
    // fault sources, trip detection and power transitions
    always_comb begin
        normal   = (r_q.pwr == pack_protection_pkg::ST_NORMAL);
        phase_on = (phase_cnt < 16'(BAL_ON_TICKS));
        // guard covers own high and its echo
        ext_det = ~r_q.alert & (r_q.low_age == 2'(pack_protection_pkg::EXT_GUARD_CYC))
                  & r_q.sync2[pack_protection_pkg::SY_ALRT];
        set_vec = '0;
        set_vec[pack_protection_pkg::ST_OV]   = normal & r_q.conv & i_ov_cond;
        set_vec[pack_protection_pkg::ST_UV]   = normal & r_q.conv & i_uv_cond;
        set_vec[pack_protection_pkg::ST_OCD]  = ocd_fire;
        set_vec[pack_protection_pkg::ST_SCD]  = scd_fire;
        set_vec[pack_protection_pkg::ST_EXT]  = ext_det;
        set_vec[pack_protection_pkg::ST_CHIP] = r_q.sync2[pack_protection_pkg::SY_CHIP];
        enter_sleep = normal & r_q.shut_arm & wr & (i_wb_req.adr == pack_protection_pkg::OFS_CTRL1)
                      & i_wb_req.dat[pack_protection_pkg::C1_SHUT_A] & ~i_wb_req.dat[pack_protection_pkg::C1_SHUT_B];
        wake = ~normal & r_q.sync2[pack_protection_pkg::SY_WAKE];
        clr_chg = set_vec[pack_protection_pkg::ST_OV] | set_vec[pack_protection_pkg::ST_EXT]
                  | set_vec[pack_protection_pkg::ST_CHIP] | enter_sleep;
        clr_dsg = set_vec[pack_protection_pkg::ST_UV] | set_vec[pack_protection_pkg::ST_OCD]
                  | set_vec[pack_protection_pkg::ST_SCD] | set_vec[pack_protection_pkg::ST_EXT]
                  | set_vec[pack_protection_pkg::ST_CHIP] | enter_sleep;
    end

    // ************************************************************
    // next state
    // ************************************************************
    // register updates, protection actions and registered outputs
    always_comb begin
        r_d = r_q;
        r_d.sync1    = {i_wake_pin, i_alert_pin, i_load_pin, i_chip_fault, i_scd_cmp, i_ocd_cmp};
        r_d.sync2    = r_q.sync1;
        r_d.alert_oe = 1'b1;
        r_d.rsp.ack  = hit & ~r_q.rsp.ack;
        r_d.rsp.dat  = (hit & ~r_q.rsp.ack) ? rdata : 32'h0000_0000;
        // zeros and concurrent faults keep bits
        r_d.status = (r_q.status & ~(wr_stat ? i_wb_req.dat[5:0] : 6'h00)) | set_vec;
        // one bit per cell in three registers
        if (wr && i_wb_req.adr == pack_protection_pkg::OFS_EQ0) begin
            r_d.eq[4:0] = i_wb_req.dat[4:0];
        end
        if (wr && i_wb_req.adr == pack_protection_pkg::OFS_EQ1) begin
            r_d.eq[9:5] = i_wb_req.dat[4:0];
        end
        if (wr && i_wb_req.adr == pack_protection_pkg::OFS_EQ2) begin
            r_d.eq[14:10] = i_wb_req.dat[4:0];
        end
        if (wr && i_wb_req.adr == pack_protection_pkg::OFS_CTRL1) begin
            r_d.conv     = i_wb_req.dat[pack_protection_pkg::C1_CONV];
            r_d.shut_arm = ~i_wb_req.dat[pack_protection_pkg::C1_SHUT_A]
                           & i_wb_req.dat[pack_protection_pkg::C1_SHUT_B];
        end
        if (wr && i_wb_req.adr == pack_protection_pkg::OFS_DELAY) begin
            r_d.ocd_dly = i_wb_req.dat[7:0];
            if (i_wb_req.sel[1]) begin
                r_d.scd_dly = i_wb_req.dat[15:8];
            end
        end
        // only a host write raises enables
        if (wr_ctrl2) begin
            r_d.charge_driver_pin = i_wb_req.dat[pack_protection_pkg::C2_CHG];
            r_d.discharge_driver_pin = i_wb_req.dat[pack_protection_pkg::C2_DSG];
        end
        if (clr_chg) begin
            r_d.charge_driver_pin = 1'b0;
        end
        if (clr_dsg) begin
            r_d.discharge_driver_pin = 1'b0;
        end
        // power state machine
        case (r_q.pwr)
            pack_protection_pkg::ST_SLEEP: begin
                if (wake) begin
                    r_d.pwr = pack_protection_pkg::ST_NORMAL;
                end
            end
            default: begin
                if (enter_sleep) begin
                    r_d.pwr      = pack_protection_pkg::ST_SLEEP;
                    r_d.shut_arm = 1'b0;
                end
            end
        endcase
        // chip fault or wake wipes balancing
        if (set_vec[pack_protection_pkg::ST_CHIP] || wake) begin
            r_d.eq = 15'h0000;
        end
        r_d.bal_out = (normal && phase_on) ? r_d.eq : 15'h0000;
        r_d.meas    = normal & r_q.conv & ~phase_on;
        // load sensed only with charge off
        r_d.load = ~r_q.charge_driver_pin & r_q.sync2[pack_protection_pkg::SY_LOAD];
        r_d.alert   = |r_d.status;
        r_d.low_age = r_q.alert ? 2'h0 :
                      (r_q.low_age == 2'(pack_protection_pkg::EXT_GUARD_CYC)) ? r_q.low_age
                      : 2'(r_q.low_age + 2'h1);
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_q         <= '0;
            r_q.pwr     <= pack_protection_pkg::ST_SLEEP;
            r_q.ocd_dly <= pack_protection_pkg::OCD_DELAY_RST;
            r_q.scd_dly <= pack_protection_pkg::SCD_DELAY_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // drivers are the enable flip-flops
    assign o_chg_drv    = r_q.charge_driver_pin;
    assign o_dsg_drv    = r_q.discharge_driver_pin;
    assign o_wb_rsp     = r_q.rsp;
    assign o_alert_out  = r_q.alert;
    assign o_alert_oe   = r_q.alert_oe;
    assign o_balance    = r_q.bal_out;
    assign o_meas_slice = r_q.meas;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    fet_follow_a: assert property (wr_ctrl2 && i_wb_req.dat[0] && !clr_chg |=> o_chg_drv)
        else $error("charge driver did not follow enable write");
    ov_clears_chg_a: assert property (set_vec[pack_protection_pkg::ST_OV] |=> !o_chg_drv ##1 !o_chg_drv || wr_ctrl2)
        else $error("charge enable survived cell high fault");
    no_self_set_a: assert property ($rose(o_chg_drv) |-> $past(wr_ctrl2))
        else $error("charge enable raised without host write");
    ov_reassert_a: assert property (normal && r_q.conv && i_ov_cond |=> r_q.status[pack_protection_pkg::ST_OV])
        else $error("cell high fault not set while present");
    load_gate_a: assert property (o_chg_drv |=> !r_q.load)
        else $error("load sensed while charge enabled");
    slice_idle_a: assert property (o_meas_slice |-> o_balance == 15'h0000)
        else $error("balancing active during measurement slice");
    wake_clear_a: assert property (wake |=> r_q.eq == 15'h0000 ##1 o_balance == 15'h0000)
        else $error("balance bits kept across wake");
    alert_release_a: assert property ($fell(o_alert_out) |-> $past(wr_stat))
        else $error("interrupt released without status clear");
    ext_trip_a: assert property (ext_det |=> r_q.status[pack_protection_pkg::ST_EXT] && !o_chg_drv && !o_dsg_drv)
        else $error("external trip not latched");
    own_high_a: assert property (o_alert_out |-> !ext_det)
        else $error("external trip seen while driving high");
    keep_set_a: assert property (wr_stat && set_vec[0] |=> r_q.status[0])
        else $error("status bit lost to concurrent clear");

    ext_trip_c: cover property (ext_det ##1 o_alert_out);
    ocd_trip_c: cover property (ocd_fire ##1 !o_dsg_drv);
    clear_c: cover property (wr_stat ##1 $fell(o_alert_out));
endmodule

/* File: core/pack_protection_pkg.sv */
/*
 * Shared constants and types of the pack protection control block:
 * register offsets, field positions, reset values, timing counts and carriers.
 * Assumes a 200 MHz system clock and a 32-bit classic Wishbone register bus.
 */
package pack_protection_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_HZ           = 200_000_000;
    localparam int unsigned SAMPLE_HZ        = 32_000;
    localparam int unsigned SAMPLE_DIV_CYC   = CLK_HZ / SAMPLE_HZ;
    localparam int unsigned BAL_PERIOD_MS    = 250;
    localparam int unsigned BAL_PERIOD_TICKS = BAL_PERIOD_MS * SAMPLE_HZ / 1000;
    localparam int unsigned BAL_DUTY_PCT     = 70;
    localparam int unsigned EXT_GUARD_CYC    = 3;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_EQ0    = 8'h04;
    localparam logic [7:0] OFS_EQ1    = 8'h08;
    localparam logic [7:0] OFS_EQ2    = 8'h0C;
    localparam logic [7:0] OFS_CTRL1  = 8'h10;
    localparam logic [7:0] OFS_CTRL2  = 8'h14;
    localparam logic [7:0] OFS_DELAY  = 8'h18;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int ST_OCD  = 0;
    localparam int ST_SCD  = 1;
    localparam int ST_OV   = 2;
    localparam int ST_UV   = 3;
    localparam int ST_EXT  = 4;
    localparam int ST_CHIP = 5;
    localparam int ST_W    = 6;
    localparam int EQ_W    = 5;
    localparam int C1_SHUT_B = 0;
    localparam int C1_SHUT_A = 1;
    localparam int C1_CONV   = 4;
    localparam int C1_SLEEP  = 6;
    localparam int C1_LOAD   = 7;
    localparam int C2_CHG    = 0;
    localparam int C2_DSG    = 1;
    // synchroniser lanes
    localparam int SY_OCD  = 0;
    localparam int SY_SCD  = 1;
    localparam int SY_CHIP = 2;
    localparam int SY_LOAD = 3;
    localparam int SY_ALRT = 4;
    localparam int SY_WAKE = 5;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] OCD_DELAY_RST = 8'h08;
    localparam logic [7:0] SCD_DELAY_RST = 8'h02;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        ST_SLEEP  = 2'b01,
        ST_NORMAL = 2'b10
    } power_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        power_state_t    pwr;
        logic [5:0]      sync1;
        logic [5:0]      sync2;
        wb_rsp_t         rsp;
        logic [ST_W-1:0] status;
        logic            charge_driver_pin;
        logic            discharge_driver_pin;
        logic [14:0]     eq;
        logic            conv;
        logic            shut_arm;
        logic [7:0]      ocd_dly;
        logic [7:0]      scd_dly;
        logic            load;
        logic            alert;
        logic            alert_oe;
        logic [1:0]      low_age;
        logic [14:0]     bal_out;
        logic            meas;
    } ctrl_state_t;

endpackage

/* File: core/tick_divider.sv */
/*
 * Enable-driven modulo counter: pulses o_tick once every DIV enabled cycles
 * and exposes the running count. Assumes DIV fits in 16 bits.
 */
`timescale 1ns/1ps
module tick_divider #(
    parameter int unsigned DIV = 16
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_en,
    output logic             o_tick,
    output logic [15:0]      o_count
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } div_state_t;

    div_state_t r_q;
    div_state_t r_d;

    // ************************************************************
    // counting
    // ************************************************************
    // wrap at DIV-1 and pulse for one cycle on the wrap
    always_comb begin
        r_d = r_q;
        r_d.tick = 1'b0;
        if (i_en) begin
            if (r_q.cnt == 16'(DIV - 1)) begin
                r_d.cnt  = 16'h0000;
                r_d.tick = 1'b1;
            end else begin
                r_d.cnt = 16'(r_q.cnt + 16'h0001);
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign o_tick  = r_q.tick;
    assign o_count = r_q.cnt;
endmodule

/* File: core/trip_qualifier.sv */
/*
 * Sampled comparator qualifier: counts sample ticks while the comparator
 * stays high and fires once the programmed delay count is reached.
 * Assumes i_cmp is already synchronised and i_tick is a one-cycle enable.
 */
`timescale 1ns/1ps
module trip_qualifier (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_tick,
    input  wire logic       i_arm,
    input  wire logic       i_cmp,
    input  wire logic [7:0] i_delay,
    output logic            o_fire
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       fire;
    } trip_state_t;

    trip_state_t r_q;
    trip_state_t r_d;

    // ************************************************************
    // hold counter
    // ************************************************************
    // delay count on samples
    always_comb begin
        r_d = r_q;
        r_d.fire = 1'b0;
        if (!i_arm || !i_cmp) begin
            r_d.cnt = 8'h00;
        end else if (i_tick) begin
            if (r_q.cnt >= i_delay) begin
                r_d.fire = 1'b1;
                r_d.cnt  = 8'h00;
            end else begin
                r_d.cnt = 8'(r_q.cnt + 8'h01);
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign o_fire = r_q.fire;
endmodule

/* File: tb/host_model.sv */
/* host side: classic wishbone master tasks.
   assumes a slave that acks each request. */
`timescale 1ns/1ps
module host_model (
    input  wire logic                         i_sys_clk,
    input  wire pack_protection_pkg::wb_rsp_t i_wb_rsp,
    output pack_protection_pkg::wb_req_t      o_wb_req
);
    initial o_wb_req = '0;
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge i_sys_clk);
        o_wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
        // hold the request until ack is sampled high; only the bench watchdog ends a hang
        do begin
            @(posedge i_sys_clk);
        end while (i_wb_rsp.ack !== 1'b1);
        q = i_wb_rsp.dat;
        o_wb_req <= '0;
        @(posedge i_sys_clk);
    endtask
endmodule

/* File: tb/pack_protection_control_tb.sv */
/* bench: pins driven here, registers via host_model.
   assumes short sample and period counts. */
`timescale 1ns/1ps
module pack_protection_control_tb;
    logic        clk, rst_n, ov, uv, discharge_overcurrent_fault, discharge_short_fault, chip, ldx, wake, ext;
    logic        aout, aoe, charge_driver_pin, discharge_driver_pin, meas;
    logic [14:0] bal, exp_bal;
    logic [31:0] rv, exp_eq, exp_st;
    logic [31:0] seed = 32'h0000003B;
    int          n_errors = 0;
    int          compares = 0;
    pack_protection_pkg::wb_req_t req;
    pack_protection_pkg::wb_rsp_t rsp;
    wire alert_w = (aoe & aout) | ext; // pulled down otherwise
    pack_protection_control #(.SAMPLE_DIV(4), .PERIOD_TICKS(20)) DUT (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_wb_req(req), .o_wb_rsp(rsp), .i_ov_cond(ov), .i_uv_cond(uv), .i_ocd_cmp(discharge_overcurrent_fault), .i_scd_cmp(discharge_short_fault),
        .i_chip_fault(chip), .i_load_pin(charge_driver_pin | ldx), .i_wake_pin(wake), .i_alert_pin(alert_w),
        .o_alert_out(aout), .o_alert_oe(aoe), .o_chg_drv(charge_driver_pin), .o_dsg_drv(discharge_driver_pin), .o_balance(bal),
        .o_meas_slice(meas));
    host_model host (.i_sys_clk(clk), .i_wb_rsp(rsp), .o_wb_req(req));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("Error %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rv);
    endtask
    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, '0, rv);
    endtask
    task automatic wait_alert();
        for (int i = 0; i < 300 && aout !== 1'b1; i++) @(posedge clk);
        chk(aout, 1);
    endtask
    task automatic complete_run();
        if (n_errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #200000;
        n_errors++;
        complete_run();
    end
    initial begin
        {ov, uv, discharge_overcurrent_fault, discharge_short_fault, chip, ldx, wake, ext} = '0;
        rst_n = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1;
        wake <= 1;
        repeat (6) @(posedge clk);
        wake <= 0;
        rd(8'h04);
        chk(rv, 0);
        rd(8'h1C);
        chk(rv, 0);
        for (int g = 0; g < 3; g++) begin
            // only cells 1, 3, 5 of a group, never neighbours inside a group
            exp_eq = (rnd() & 32'h15) | 32'h1;
            exp_bal[5*g +: 5] = exp_eq[4:0];
            wr(8'(4 + 4 * g), exp_eq);
            rd(8'(4 + 4 * g));
            chk(rv, exp_eq);
        end
        for (int i = 0; i < 200 && bal === 15'h0000; i++) @(posedge clk);
        chk(bal, exp_bal);
        for (int i = 0; i < 200 && bal !== 15'h0000; i++) @(posedge clk);
        chk(bal, 0);
        wr(8'h10, 32'h10);
        // ************ cell limit faults ************
        for (int k = 0; k < 2; k++) begin
            wr(8'h14, 32'h3);
            chk({charge_driver_pin, discharge_driver_pin}, 2'b11);
            ov <= (k == 0);
            uv <= (k == 1);
            wait_alert();
            chk({charge_driver_pin, discharge_driver_pin}, k ? 2'b10 : 2'b01);
            exp_st = k ? 32'h8 : 32'h4;
            wr(8'h00, exp_st);
            rd(8'h00);
            chk(rv, exp_st);
            ov <= 0;
            uv <= 0;
            wr(8'h00, 32'h0);
            rd(8'h00);
            chk(rv, exp_st);
            wr(8'h00, exp_st);
            chk(aout, 0);
        end
        wr(8'h14, 32'h3);
        ldx <= 1;
        ext <= 1;
        repeat (6) @(posedge clk);
        ext <= 0;
        chk({charge_driver_pin, discharge_driver_pin}, 0);
        rd(8'h00);
        chk(rv, 32'h10);
        rd(8'h10);
        chk(rv, 32'h90);
        ldx <= 0;
        // let the pin pass the synchroniser and the load flop
        repeat (2) @(posedge clk);
        rd(8'h10);
        chk(rv, 32'h10);
        wr(8'h00, 32'h10);
        ov <= 1;
        wait_alert();
        ext <= 1;
        repeat (6) @(posedge clk);
        ext <= 0;
        ov <= 0;
        rd(8'h00);
        chk(rv, 32'h4);
        wr(8'h00, 32'h4);
        wr(8'h14, 32'h3);
        discharge_overcurrent_fault <= 1;
        wait_alert();
        discharge_overcurrent_fault <= 0;
        chk({charge_driver_pin, discharge_driver_pin}, 2'b10);
        // host drops charge enable after discharge trip
        wr(8'h14, 32'h0);
        ldx <= 1;
        for (int i = 0; i < 20 && rv[7] !== 1'b1; i++) rd(8'h10);
        chk(rv[7], 1);
        ldx <= 0;
        for (int i = 0; i < 20 && rv[7] !== 1'b0; i++) rd(8'h10);
        chk(rv[7], 0);
        wr(8'h00, 32'h1);
        wr(8'h14, 32'h3);
        chip <= 1;
        wait_alert();
        chip <= 0;
        chk({charge_driver_pin, discharge_driver_pin}, 0);
        rd(8'h04);
        chk(rv, 0);
        repeat (4) @(posedge clk);
        wr(8'h00, 32'h20);
        chk(aout, 0);
        wr(8'h14, 32'h3);
        wr(8'h10, 32'h1);
        wr(8'h10, 32'h2);
        chk({charge_driver_pin, discharge_driver_pin}, 0);
        complete_run();
    end
endmodule
